// file: td_rate_regs_defines.vh
// Constants for the trace driver per-rate parameter registers.
// Assumes 16-bit register words addressed by an 8-bit word address.
`ifndef TD_RATE_REGS_DEFINES_VH
`define TD_RATE_REGS_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_OUT0_FAST_RATE_PREEMPH_CTRL 8'h32
`define OFS_OUT0_FAST_RATE_SWING_CTRL   8'h33
`define OFS_RESERVED_WORD_A             8'h34
`define OFS_RESERVED_WORD_B             8'h35
`define OFS_RESERVED_WORD_C             8'h36
`define OFS_RESERVED_WORD_D             8'h37
`define OFS_OUT1_BYPASS_PREEMPH_CTRL    8'h38
`define OFS_FIRST                       8'h32
`define OFS_LAST                        8'h38

// ----------------------------------------
// Word slots inside the store
// ----------------------------------------
`define NUM_WORDS                       7
`define IDX_FAST_EMPH                   3'h0
`define IDX_FAST_SWING                  3'h1
`define IDX_RESERVED_A                  3'h2
`define IDX_RESERVED_B                  3'h3
`define IDX_RESERVED_C                  3'h4
`define IDX_RESERVED_D                  3'h5
`define IDX_BYPASS_EMPH                 3'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EMPH_WIDTH_MSB                  12
`define EMPH_WIDTH_LSB                  8
`define EMPH_OFF_BIT                    6
`define EMPH_LEVEL_MSB                  5
`define EMPH_LEVEL_LSB                  0
`define SWING_MSB                       13
`define SWING_LSB                       8

// ----------------------------------------
// Reset values (whole words with reserved bits included, then single fields)
// ----------------------------------------
`define RST_EMPH_WORD                   16'h0201
`define RST_SWING_WORD                  16'h1170
`define RST_WIDTH                       5'h02
`define RST_OFF                         1'h0
`define RST_LEVEL                       6'h01
`define RST_SWING                       6'h11

`endif

// file: td_param_store.v
// Seven-word store for the per-rate trace driver parameters.
// Assumes the caller decodes addresses; read data are registered here.
`timescale 1ns/1ns
`include "td_rate_regs_defines.vh"

module td_param_store (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        wr_en,
    input  wire [2:0]  wr_idx,
    input  wire [15:0] wr_data,
    input  wire        rd_en,
    input  wire        rd_hit,
    input  wire [2:0]  rd_idx,
    output reg  [15:0] rd_data_q,
    output wire [15:0] fast_emph_word,
    output wire [15:0] fast_swing_word,
    output wire [15:0] bypass_emph_word
);

    wire [16*`NUM_WORDS-1:0] words;

    // ----------------------------------------
    // Word storage
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < `NUM_WORDS; i = i + 1) begin : g_word
            // Odd slots hold the swing pattern, even slots the emphasis pattern
            localparam [15:0] RST = (i % 2 == 1) ? `RST_SWING_WORD : `RST_EMPH_WORD;
            localparam [2:0]  SLOT = i;
            reg [15:0] word_q;
            always @(posedge clock) begin
                if (sys_rst) begin
                    word_q <= RST;
                end else if (wr_en && wr_idx == SLOT) begin
                    word_q <= wr_data;
                end
            end
            assign words[16*i +: 16] = word_q;
        end
    endgenerate

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always @(posedge clock) begin
        if (sys_rst) begin
            rd_data_q <= 16'h0000;
        end else if (rd_en) begin
            // Unmapped reads answer zero
            rd_data_q <= rd_hit ? words[16*rd_idx +: 16] : 16'h0000;
        end
    end

    assign fast_emph_word   = words[16*`IDX_FAST_EMPH +: 16];
    assign fast_swing_word  = words[16*`IDX_FAST_SWING +: 16];
    assign bypass_emph_word = words[16*`IDX_BYPASS_EMPH +: 16];

endmodule // td_param_store

// file: trace_driver_rate_param_regs.v
// Per-rate trace driver parameter registers and driver setting steering.
// Assumes a serial control port decoder on the same clock issues word
// reads and writes; lock, rate and neighbouring settings come from core
// logic on this clock, so they are not resynchronised.
//
// What this block does
// - Output0 fast pulse width, bits 12:8, reset 2
// - Output0 fast power-down bit 6, reset 0
// - Output0 fast amplitude bits 5:0, reset 1
// - Output0 fast swing bits 13:8, reset 11h
// - Output1 bypass pulse width bits 12:8, reset 2
// - Output1 bypass power-down bit 6, reset 0
// - Output1 bypass amplitude bits 5:0, reset 1
// - Output1 unlocked with per-rate on uses bypass set
`timescale 1ns/1ns
`include "td_rate_regs_defines.vh"

module trace_driver_rate_param_regs (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    output wire [15:0] reg_rdata,
    output reg         reg_rvalid_q,
    output reg         reg_rhit_q,
    input  wire        out0_per_rate_select,
    input  wire        out1_per_rate_select,
    input  wire        cdr_locked,
    input  wire        rate_is_fast,
    input  wire [15:0] out0_alt_emph_word,
    input  wire [15:0] out0_alt_swing_word,
    input  wire [15:0] out1_rate_emph_word,
    input  wire [15:0] out1_rate_swing_word,
    input  wire [5:0]  out1_bypass_swing,
    output reg  [4:0]  driver_output_a_width_q,
    output reg         driver_output_a_emph_off_q,
    output reg  [5:0]  driver_output_a_level_q,
    output reg  [5:0]  driver_output_a_swing_q,
    output reg  [4:0]  driver_output_b_width_q,
    output reg         driver_output_b_emph_off_q,
    output reg  [5:0]  driver_output_b_level_q,
    output reg  [5:0]  driver_output_b_swing_q
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    reg         addr_hit;
    reg  [2:0]  word_idx;
    wire [15:0] fast_emph_word;
    wire [15:0] fast_swing_word;
    wire [15:0] bypass_emph_word;

    // Explicit offsets, so a hole in the map never aliases a slot
    always @* begin
        addr_hit = 1'h1;
        word_idx = `IDX_FAST_EMPH;
        case (reg_addr)
            `OFS_OUT0_FAST_RATE_PREEMPH_CTRL: begin
                word_idx = `IDX_FAST_EMPH;
            end
            `OFS_OUT0_FAST_RATE_SWING_CTRL: begin
                word_idx = `IDX_FAST_SWING;
            end
            `OFS_RESERVED_WORD_A: begin
                word_idx = `IDX_RESERVED_A;
            end
            `OFS_RESERVED_WORD_B: begin
                word_idx = `IDX_RESERVED_B;
            end
            `OFS_RESERVED_WORD_C: begin
                word_idx = `IDX_RESERVED_C;
            end
            `OFS_RESERVED_WORD_D: begin
                word_idx = `IDX_RESERVED_D;
            end
            `OFS_OUT1_BYPASS_PREEMPH_CTRL: begin
                word_idx = `IDX_BYPASS_EMPH;
            end
            default: begin
                addr_hit = 1'h0;
                word_idx = `IDX_FAST_EMPH;
            end
        endcase
    end

    // Reserved words stay writable; leaving them alone is software's job
    td_param_store u_store (
        .clock            (clock),
        .sys_rst          (sys_rst),
        .wr_en            (reg_wr && addr_hit),
        .wr_idx           (word_idx),
        .wr_data          (reg_wdata),
        .rd_en            (reg_rd),
        .rd_hit           (addr_hit),
        .rd_idx           (word_idx),
        .rd_data_q        (reg_rdata),
        .fast_emph_word   (fast_emph_word),
        .fast_swing_word  (fast_swing_word),
        .bypass_emph_word (bypass_emph_word)
    );

    always @(posedge clock) begin
        if (sys_rst) begin
            reg_rvalid_q <= 1'b0;
            reg_rhit_q   <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            reg_rhit_q   <= reg_rd && addr_hit;
        end
    end

    // ----------------------------------------
    // Field extraction per parameter set
    // ----------------------------------------
    wire [4:0]  out0_fast_emph_pulse_width;
    wire        out0_fast_emph_power_off;
    wire [5:0]  out0_fast_emph_level;
    wire [5:0]  out0_fast_drive_swing;
    wire [4:0]  alt0_width;
    wire        alt0_off;
    wire [5:0]  alt0_level;
    wire [5:0]  alt0_swing;
    wire [4:0]  bypass1_width;
    wire        bypass1_off;
    wire [5:0]  bypass1_level;
    wire [4:0]  rate1_width;
    wire        rate1_off;
    wire [5:0]  rate1_level;
    wire [5:0]  rate1_swing;

    // Range limits are not enforced; out-of-range codes reach the driver
    assign out0_fast_emph_pulse_width = fast_emph_word[`EMPH_WIDTH_MSB:`EMPH_WIDTH_LSB];
    assign out0_fast_emph_power_off   = fast_emph_word[`EMPH_OFF_BIT];
    assign out0_fast_emph_level       = fast_emph_word[`EMPH_LEVEL_MSB:`EMPH_LEVEL_LSB];
    assign out0_fast_drive_swing      = fast_swing_word[`SWING_MSB:`SWING_LSB];
    assign alt0_width                 = out0_alt_emph_word[`EMPH_WIDTH_MSB:`EMPH_WIDTH_LSB];
    assign alt0_off                   = out0_alt_emph_word[`EMPH_OFF_BIT];
    assign alt0_level                 = out0_alt_emph_word[`EMPH_LEVEL_MSB:`EMPH_LEVEL_LSB];
    assign alt0_swing                 = out0_alt_swing_word[`SWING_MSB:`SWING_LSB];
    assign bypass1_width              = bypass_emph_word[`EMPH_WIDTH_MSB:`EMPH_WIDTH_LSB];
    assign bypass1_off                = bypass_emph_word[`EMPH_OFF_BIT];
    assign bypass1_level              = bypass_emph_word[`EMPH_LEVEL_MSB:`EMPH_LEVEL_LSB];
    assign rate1_width                = out1_rate_emph_word[`EMPH_WIDTH_MSB:`EMPH_WIDTH_LSB];
    assign rate1_off                  = out1_rate_emph_word[`EMPH_OFF_BIT];
    assign rate1_level                = out1_rate_emph_word[`EMPH_LEVEL_MSB:`EMPH_LEVEL_LSB];
    assign rate1_swing                = out1_rate_swing_word[`SWING_MSB:`SWING_LSB];

    // ----------------------------------------
    // Parameter set selection
    // ----------------------------------------
    wire        out0_fast_sel;
    wire        out1_bypass_sel;
    reg  [4:0]  a_width_d;
    reg         a_off_d;
    reg  [5:0]  a_level_d;
    reg  [5:0]  a_swing_d;
    reg  [4:0]  b_width_d;
    reg         b_off_d;
    reg  [5:0]  b_level_d;
    reg  [5:0]  b_swing_d;

    // Output0: fast set only when locked at the fast rate
    assign out0_fast_sel   = out0_per_rate_select && cdr_locked && rate_is_fast;
    // Output1: bypass set whenever unlocked with per-rate select on, whatever the rate
    assign out1_bypass_sel = out1_per_rate_select && !cdr_locked;

    always @* begin
        if (out0_fast_sel) begin
            a_width_d = out0_fast_emph_pulse_width;
            a_off_d   = out0_fast_emph_power_off;
            a_level_d = out0_fast_emph_level;
            a_swing_d = out0_fast_drive_swing;
        end else begin
            // Unlocked falls to the neighbouring bypass/other-rate set
            a_width_d = alt0_width;
            a_off_d   = alt0_off;
            a_level_d = alt0_level;
            a_swing_d = alt0_swing;
        end
        if (out1_bypass_sel) begin
            b_width_d = bypass1_width;
            b_off_d   = bypass1_off;
            b_level_d = bypass1_level;
            b_swing_d = out1_bypass_swing;
        end else begin
            b_width_d = rate1_width;
            b_off_d   = rate1_off;
            b_level_d = rate1_level;
            b_swing_d = rate1_swing;
        end
    end

    // ----------------------------------------
    // Driver setting outputs
    // ----------------------------------------
    // One cycle of latency keeps the analogue controls glitch free
    always @(posedge clock) begin
        if (sys_rst) begin
            driver_output_a_width_q    <= `RST_WIDTH;
            driver_output_a_emph_off_q <= `RST_OFF;
            driver_output_a_level_q    <= `RST_LEVEL;
            driver_output_a_swing_q    <= `RST_SWING;
        end else begin
            driver_output_a_width_q    <= a_width_d;
            driver_output_a_emph_off_q <= a_off_d;
            driver_output_a_level_q    <= a_level_d;
            driver_output_a_swing_q    <= a_swing_d;
        end
    end

    // One block per output keeps each driver's controls together
    always @(posedge clock) begin
        if (sys_rst) begin
            driver_output_b_width_q    <= `RST_WIDTH;
            driver_output_b_emph_off_q <= `RST_OFF;
            driver_output_b_level_q    <= `RST_LEVEL;
            driver_output_b_swing_q    <= `RST_SWING;
        end else begin
            driver_output_b_width_q    <= b_width_d;
            driver_output_b_emph_off_q <= b_off_d;
            driver_output_b_level_q    <= b_level_d;
            driver_output_b_swing_q    <= b_swing_d;
        end
    end

endmodule // trace_driver_rate_param_regs

// file: td_rate_regs_assertions.sv
// Checker for the per-rate trace driver registers.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ns
module td_rate_regs_checker (
    input logic        clock,
    input logic        sys_rst,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [7:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    input logic        reg_rvalid_q,
    input logic        reg_rhit_q,
    input logic        out0_per_rate_select,
    input logic        out1_per_rate_select,
    input logic        cdr_locked,
    input logic        rate_is_fast,
    input logic [15:0] out0_alt_swing_word,
    input logic [5:0]  out1_bypass_swing,
    input logic [4:0]  driver_output_a_width_q,
    input logic        driver_output_a_emph_off_q,
    input logic [5:0]  driver_output_a_level_q,
    input logic [5:0]  driver_output_a_swing_q,
    input logic [4:0]  driver_output_b_width_q,
    input logic        driver_output_b_emph_off_q,
    input logic [5:0]  driver_output_b_level_q,
    input logic [5:0]  driver_output_b_swing_q
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire mapped  = reg_addr >= 8'h32 && reg_addr <= 8'h38;
    wire byp_on  = out1_per_rate_select && !cdr_locked;
    wire fast_on = out0_per_rate_select && cdr_locked && rate_is_fast;
    sequence byp_wr; reg_wr && reg_addr == 8'h38 && byp_on; endsequence
    sequence fast_wr; reg_wr && reg_addr == 8'h33 && fast_on; endsequence
    a_rvalid_pulse: assert property (reg_rd |=> reg_rvalid_q)
        else $error("read not answered");
    a_rvalid_quiet: assert property (!reg_rd |=> !reg_rvalid_q)
        else $error("spurious read answer");
    a_mapped_hit: assert property (reg_rd && mapped |=> reg_rhit_q)
        else $error("mapped read missed");
    a_unmapped_zero: assert property (reg_rd && !mapped |=>
        !reg_rhit_q && reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_reset_drive: assert property ($fell(sys_rst) |->
        driver_output_a_width_q == 5'h02
        && !driver_output_a_emph_off_q && driver_output_a_level_q == 6'h01
        && driver_output_a_swing_q == 6'h11)
        else $error("driver reset values wrong");
    a_bypass_fields: assert property (byp_wr ##1 (byp_on && !reg_wr) |=>
        {driver_output_b_width_q, driver_output_b_emph_off_q, driver_output_b_level_q}
        == {$past(reg_wdata[12:8], 2), $past(reg_wdata[6], 2), $past(reg_wdata[5:0], 2)})
        else $error("bypass set not applied");
    a_bypass_swing: assert property (byp_on |=>
        driver_output_b_swing_q == $past(out1_bypass_swing))
        else $error("bypass swing not applied");
    a_fast_swing: assert property (fast_wr ##1 (fast_on && !reg_wr) |=>
        driver_output_a_swing_q == $past(reg_wdata[13:8], 2))
        else $error("fast swing not applied");
    a_alt_swing: assert property (!fast_on |=>
        driver_output_a_swing_q == $past(out0_alt_swing_word[13:8]))
        else $error("alternate swing not applied");
endmodule // td_rate_regs_checker

bind trace_driver_rate_param_regs td_rate_regs_checker chk_u (.*);

// file: trace_driver_rate_param_regs_tb.sv
// Self-checking bench for the per-rate trace driver registers.
// Assumes the design and its checker are compiled alongside.
`timescale 1ns/1ns
module trace_driver_rate_param_regs_tb;
    logic        clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, cdr_locked = 0, rate_is_fast = 0;
    logic        out0_per_rate_select = 0, out1_per_rate_select = 0, reg_rvalid_q, reg_rhit_q;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, out0_alt_emph_word = 16'h0000, out0_alt_swing_word = 16'h0000;
    logic [15:0] out1_rate_emph_word = 16'h0000, out1_rate_swing_word = 16'h0000, reg_rdata;
    logic [5:0]  out1_bypass_swing = 6'h00, driver_output_a_level_q, driver_output_a_swing_q;
    logic [5:0]  driver_output_b_level_q, driver_output_b_swing_q;
    logic [4:0]  driver_output_a_width_q, driver_output_b_width_q;
    logic        driver_output_a_emph_off_q, driver_output_b_emph_off_q;
    int          fail_count = 0, tests_run = 0;
    logic [15:0] mem [0:6];
    logic [16:0] expq [$];
    logic [31:0] seed = 32'h7110BCCC;
    trace_driver_rate_param_regs dut_u (.*);
    always #20 clock = ~clock;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [17:0] fld(input logic [15:0] e, input logic [15:0] s);
        return {e[12:8], e[6], e[5:0], s[13:8]};
    endfunction
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        if (a >= 8'h32 && a <= 8'h38) mem[a - 8'h32] = d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_all();
        for (int i = 8'h31; i <= 8'h39; i++) begin
            @(posedge clock);
            reg_rd <= 1'b1;
            reg_addr <= i[7:0];
            expq.push_back((i >= 8'h32 && i <= 8'h38) ? {1'b1, mem[i - 8'h32]} : 17'h00000);
            @(posedge clock);
            reg_rd <= 1'b0;
        end
    endtask
    // Random neighbour sets each time, so a stuck select shows up
    task automatic steer(input logic s0, input logic s1, input logic lk, input logic fs);
        @(posedge clock);
        out0_per_rate_select <= s0;
        out1_per_rate_select <= s1;
        cdr_locked           <= lk;
        rate_is_fast         <= fs;
        out0_alt_emph_word   <= 16'(rnd());
        out0_alt_swing_word  <= 16'(rnd());
        out1_bypass_swing    <= 6'(rnd());
        out1_rate_emph_word  <= 16'(rnd());
        out1_rate_swing_word <= 16'(rnd());
        repeat (2) @(posedge clock);
        @(negedge clock);
        check({driver_output_a_width_q, driver_output_a_emph_off_q, driver_output_a_level_q,
            driver_output_a_swing_q}, (s0 && lk && fs) ? fld(mem[0], mem[1])
            : fld(out0_alt_emph_word, out0_alt_swing_word));
        check({driver_output_b_width_q, driver_output_b_emph_off_q, driver_output_b_level_q,
            driver_output_b_swing_q}, (s1 && !lk) ? fld(mem[6], {2'b00, out1_bypass_swing, 8'h00})
            : fld(out1_rate_emph_word, out1_rate_swing_word));
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Read answers are matched against the oldest note
    always @(negedge clock) if (reg_rvalid_q === 1'b1) begin
        if (expq.size() == 0) check(18'h1, 18'h0);
        else check({1'b0, reg_rhit_q, reg_rdata}, {1'b0, expq.pop_front()});
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic [5:0]  lv, sw;
        for (int i = 0; i < 7; i++) mem[i] = i[0] ? 16'h1170 : 16'h0201;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        rd_all();
        for (int n = 0; n < 5; n++) begin
            r = rnd();
            lv = (n == 0) ? 6'd50 : r[13:8] % 6'd51;
            sw = (n == 0) ? 6'd40 : r[21:16] % 6'd41;
            steer(1'b1, 1'b1, 1'b1, 1'b1);
            wr(8'h32, {3'h0, 1'b0, (n == 0) ? 4'hF : r[3:0], 1'b0, r[4], lv});
            wr(8'h33, {2'b00, sw, 8'h70});
            steer(1'b1, 1'b1, 1'b0, r[5]);
            wr(8'h38, {3'h0, 1'b0, r[25:22], 1'b0, r[26], r[31:26] % 6'd51});
            wr(8'h39, 16'hFFFF);
            rd_all();
            steer(1'b1, 1'b1, 1'b0, 1'b0);
            steer(r[6], r[7], r[8], r[9]);
        end
        for (int k = 0; k < 20 && expq.size() > 0; k++) @(posedge clock);
        if (expq.size() > 0) check(18'h1, 18'h0);
        give_verdict();
    end
endmodule // trace_driver_rate_param_regs_tb
